// ---- include/nvm_pkg.sv ----
// package of the nonvolatile command block: map, codes, layouts, types
// assumes a Wishbone slave with 8-bit registers in the low data byte
package nvm_pkg;

	// eeprom geometry: byte field [4:0], page field [7:5]
	localparam int BYTE_TOP = 4;
	localparam int PAGE_TOP = 7;
	localparam int EE_AW = PAGE_TOP + 1;
	localparam int BUF_AW = BYTE_TOP + 1;
	localparam int PAGE_BYTES = 1 << BUF_AW;
	localparam int FUSE_COUNT = 6;

	// register byte offsets
	localparam logic [7:0] OFS_ADDR = 8'h00;
	localparam logic [7:0] OFS_DATA_BYTE0_REG = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_CONTROL_A_REG = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CTRLB = 8'h14;
	localparam logic [7:0] OFS_LOCK = 8'h18;

	// field positions
	localparam int CONTROL_A_REG_EXEC_BIT = 0;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int CTRLB_MAP_BIT = 0;

	// command codes
	localparam logic [6:0] CMD_NOP = 7'h00;
	localparam logic [6:0] CMD_READ_USER_SIG = 7'h01;
	localparam logic [6:0] CMD_READ_PROD_SIG = 7'h02;
	localparam logic [6:0] CMD_READ_EEPROM = 7'h06;
	localparam logic [6:0] CMD_READ_FUSES = 7'h07;
	localparam logic [6:0] CMD_WRITE_LOCK = 7'h08;
	localparam logic [6:0] CMD_ERASE_EEPROM = 7'h30;
	localparam logic [6:0] CMD_ERASE_PAGE = 7'h32;
	localparam logic [6:0] CMD_LOAD_BUFFER = 7'h33;
	localparam logic [6:0] CMD_WRITE_PAGE = 7'h34;
	localparam logic [6:0] CMD_ERASE_WRITE_PAGE = 7'h35;
	localparam logic [6:0] CMD_ERASE_BUFFER = 7'h36;

	// reset values and constants
	localparam logic [7:0] LOCK_RESET = 8'hFF;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [1:0] MAP_STALL_CYCLES = 2'h2;
	// signature row contents are arbitrary seeds, not identity codes
	localparam logic [7:0] SIG_SEED_USER = 8'h5A;
	localparam logic [7:0] SIG_SEED_PROD = 8'hC3;

	// classic wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} wbReq_type;

	// core side: load instr, mapped eeprom load and store
	typedef struct packed {
		logic lpmReq;
		logic mapLoad;
		logic mapStore;
		logic [7:0] addr;
		logic [7:0] data;
	} coreReq_type;

	typedef enum logic [1:0] {TRIG_NONE, TRIG_EXEC, TRIG_LPM, TRIG_DATA_BYTE0_REG}
		trig_type;

endpackage : nvm_pkg

// ---- tb/core_model.sv ----
// core model: program load instr and mapped eeprom loads and stores
// assumes the bench calls one task at a time, right after a rising edge
`timescale 1ns/1ps
module core_model (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// requests toward the block
	output nvm_pkg::coreReq_type core,
	// answers from the block
	input wire logic coreHalt,
	input wire logic [7:0] lpmData,
	input wire logic lpmValid,
	input wire logic [7:0] mapRdata,
	input wire logic mapRvalid
);
	logic active = 1'b0;

	initial core = '0;

	// released qualifiers toggle so a stale value never looks valid
	always @(posedge clk) begin
		if (!active && arst_n) begin
			core.addr <= ~core.addr;
			core.data <= ~core.data;
		end
	end

	// one pulse with held qualifiers; a halted core waits up to 16 cycles, then issues anyway
	task automatic issue(input int kind, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		active = 1'b1;
		for (n = 0; n < 16 && coreHalt === 1'b1; n++)
			@(posedge clk);
		@(posedge clk);
		core.addr <= a;
		core.data <= d;
		core.lpmReq <= (kind == 0);
		core.mapLoad <= (kind == 1);
		core.mapStore <= (kind == 2);
		@(posedge clk);
		core.lpmReq <= 1'b0;
		core.mapLoad <= 1'b0;
		core.mapStore <= 1'b0;
		active = 1'b0;
	endtask : issue

	// load instr (kind 0) or mapped load (kind 1); unknown if no answer
	task automatic fetch(input int kind, input logic [7:0] a,
		output logic [7:0] d);
		d = 8'hXX;
		issue(kind, a, 8'h00);
		repeat (8) begin
			@(posedge clk);
			if (kind == 0 && lpmValid === 1'b1)
				d = lpmData;
			if (kind == 1 && mapRvalid === 1'b1)
				d = mapRdata;
		end
	endtask : fetch

	// mapped store, counting the cycles the core is held
	task automatic store(input logic [7:0] a, input logic [7:0] d,
		output int stalls);
		issue(2, a, d);
		stalls = 0;
		repeat (4) begin
			@(posedge clk);
			if (coreHalt === 1'b1)
				stalls++;
		end
	endtask : store

endmodule : core_model

// ---- tb/test_nvm_cmd_ctrl.sv ----
// bench of the nonvolatile command block: registers over wishbone
// assumes core_model on the core side and the design package
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
	failures++; $display("MISMATCH %s expected %0h seen %0h", nm, exp, \
	got); end end
module test_nvm_cmd_ctrl;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	nvm_pkg::wbReq_type wbReq = '0;
	nvm_pkg::coreReq_type core;
	logic guardOpen = 1'b0;
	logic extProg = 1'b0;
	logic [47:0] fusePins = 48'h000000000000;
	logic wbAck, lpmValid, mapRvalid, coreHalt, nvmBusy, flashBufClear;
	logic [31:0] wbDat;
	logic [7:0] lpmData, mapRdata;
	logic [31:0] seedState = 32'h00011480;
	logic hA, bA;
	logic ce = 1'b1;
	logic [7:0] pat [32];
	int failures = 0;
	int checked = 0;
	int fbcCount = 0;

	always #5 clk = ~clk;

	// flash buffer clear pulses, one per accepted lock write
	always @(posedge clk)
		if (flashBufClear === 1'b1)
			fbcCount++;

	nvm_cmd_ctrl dut_u (.clk(clk), .arst_n(arst_n), .ce(ce),
		.wbReq(wbReq), .wbAck(wbAck), .wbDat(wbDat), .core(core),
		.lpmData(lpmData), .lpmValid(lpmValid), .mapRdata(mapRdata),
		.mapRvalid(mapRvalid), .coreHalt(coreHalt), .guardOpen(guardOpen),
		.extProg(extProg), .fusePins(fusePins), .nvmBusy(nvmBusy),
		.flashBufClear(flashBufClear));

	core_model core_u (.clk(clk), .arst_n(arst_n), .core(core),
		.coreHalt(coreHalt), .lpmData(lpmData), .lpmValid(lpmValid),
		.mapRdata(mapRdata), .mapRvalid(mapRvalid));

	function automatic logic [31:0] rnd();
		seedState ^= seedState << 13;
		seedState ^= seedState >> 17;
		seedState ^= seedState << 5;
		return seedState;
	endfunction : rnd

	task automatic wrap_up();
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// classic cycle: held until ack is sampled high, then released
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [7:0] dat, output logic [7:0] rd);
		int n;
		@(posedge clk);
		wbReq <= '{1'b1, 1'b1, we, 4'hF, adr, {24'h000000, dat}};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		if (wbAck !== 1'b1) begin
			failures++;
			wrap_up();
		end
		rd = wbDat[7:0];
		wbReq <= '0;
	endtask : wb

	task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
		logic [7:0] dummy;
		wb(1'b1, adr, dat, dummy);
	endtask : wr

	task automatic rd(input logic [7:0] adr, output logic [7:0] d);
		wb(1'b0, adr, 8'h00, d);
	endtask : rd

	// select, trigger, then poll busy under a bound
	task automatic run(input logic [6:0] cmd);
		logic [7:0] s;
		int n;
		wr(nvm_pkg::OFS_CMD, {1'b0, cmd});
		wr(nvm_pkg::OFS_CONTROL_A_REG, 8'h01);
		@(posedge clk);
		hA = coreHalt;
		bA = nvmBusy;
		s = 8'h01;
		for (n = 0; n < 400 && s[0] !== 1'b0; n++)
			rd(nvm_pkg::OFS_STATUS, s);
		if (s[0] !== 1'b0) begin
			failures++;
			wrap_up();
		end
	endtask : run

	task automatic load(input logic [7:0] a, input logic [7:0] d);
		wr(nvm_pkg::OFS_ADDR, a);
		wr(nvm_pkg::OFS_DATA_BYTE0_REG, d);
	endtask : load

	task automatic ee_rd(input logic [7:0] a, output logic [7:0] d);
		wr(nvm_pkg::OFS_ADDR, a);
		run(nvm_pkg::CMD_READ_EEPROM);
		rd(nvm_pkg::OFS_DATA_BYTE0_REG, d);
	endtask : ee_rd

	initial begin
		logic [7:0] d, v;
		logic [4:0] k, m;
		int i, st;
		fusePins = 48'({rnd(), rnd()});
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		rd(nvm_pkg::OFS_LOCK, d);
		`CHECK("lock reset", nvm_pkg::LOCK_RESET, d)
		rd(8'h1C, d);
		`CHECK("unmapped", 8'h00, d)
		// fuse reads need no guard, so toggle it on the way
		for (i = 0; i < nvm_pkg::FUSE_COUNT; i++) begin
			wr(nvm_pkg::OFS_ADDR, 8'(i));
			guardOpen <= i[0];
			run(nvm_pkg::CMD_READ_FUSES);
			`CHECK("fuse halt", 1'b1, hA)
			rd(nvm_pkg::OFS_DATA_BYTE0_REG, d);
			`CHECK("fuse byte", fusePins[8*i +: 8], d)
		end
		guardOpen <= 1'b1;
		run(nvm_pkg::CMD_NOP);
		`CHECK("nop busy", 1'b0, bA)
		// fill page 3 whole so every cell has a known value
		wr(nvm_pkg::OFS_CMD, {1'b0, nvm_pkg::CMD_LOAD_BUFFER});
		for (i = 0; i < nvm_pkg::PAGE_BYTES; i++) begin
			pat[i] = 8'(rnd());
			load({3'h3, 5'(i)}, pat[i]);
		end
		@(posedge clk);
		`CHECK("load busy", 1'b0, nvmBusy)
		run(nvm_pkg::CMD_ERASE_WRITE_PAGE);
		`CHECK("page halt", 1'b0, hA)
		run(nvm_pkg::CMD_ERASE_BUFFER);
		`CHECK("buffer busy", 1'b1, bA)
		k = 5'(rnd());
		m = k + 5'h02;
		v = ~pat[k];
		wr(nvm_pkg::OFS_CMD, {1'b0, nvm_pkg::CMD_LOAD_BUFFER});
		load({3'h3, k}, v);
		run(nvm_pkg::CMD_WRITE_PAGE);
		for (i = 0; i < nvm_pkg::PAGE_BYTES; i++) begin
			ee_rd({3'h3, 5'(i)}, d);
			`CHECK("page cell", (i == k) ? v : pat[i], d)
		end
		run(nvm_pkg::CMD_ERASE_PAGE);
		ee_rd({3'h3, k + 5'h01}, d);
		`CHECK("untagged kept", pat[k + 5'h01], d)
		wr(nvm_pkg::OFS_ADDR, {3'h6, k});
		run(nvm_pkg::CMD_WRITE_PAGE);
		run(nvm_pkg::CMD_ERASE_EEPROM);
		ee_rd({3'h6, k}, d);
		`CHECK("erase all", nvm_pkg::ERASED_BYTE, d)
		// lock write: refused without guard, then only clears bits
		d = 8'(rnd()) & 8'hF3;
		wr(nvm_pkg::OFS_DATA_BYTE0_REG, d);
		guardOpen <= 1'b0;
		run(nvm_pkg::CMD_WRITE_LOCK);
		rd(nvm_pkg::OFS_LOCK, v);
		`CHECK("lock guarded", nvm_pkg::LOCK_RESET, v)
		extProg <= 1'b1;
		run(nvm_pkg::CMD_WRITE_LOCK);
		`CHECK("lock halt", 1'b1, hA)
		`CHECK("flash clear", 1, fbcCount)
		wr(nvm_pkg::OFS_DATA_BYTE0_REG, 8'hFF);
		run(nvm_pkg::CMD_WRITE_LOCK);
		rd(nvm_pkg::OFS_LOCK, v);
		`CHECK("lock value", d, v)
		extProg <= 1'b0;
		guardOpen <= 1'b1;
		wr(nvm_pkg::OFS_ADDR, {3'h3, k});
		run(nvm_pkg::CMD_WRITE_PAGE);
		ee_rd({3'h3, k}, d);
		`CHECK("tags cleared", nvm_pkg::ERASED_BYTE, d)
		for (i = 0; i < 2; i++) begin
			wr(nvm_pkg::OFS_CMD, i[0] ? {1'b0, nvm_pkg::CMD_READ_PROD_SIG} :
				{1'b0, nvm_pkg::CMD_READ_USER_SIG});
			v = 8'(rnd());
			core_u.fetch(0, v, d);
			`CHECK("signature", v ^ (i[0] ? nvm_pkg::SIG_SEED_PROD :
				nvm_pkg::SIG_SEED_USER), d)
		end
		// mapped: register load is ignored, stores fill the buffer
		wr(nvm_pkg::OFS_CTRLB, 8'h01);
		wr(nvm_pkg::OFS_CMD, {1'b0, nvm_pkg::CMD_LOAD_BUFFER});
		load({3'h3, k}, 8'h3C);
		v = 8'(rnd()) & 8'h7F;
		core_u.store({3'h3, m}, v, st);
		`CHECK("store stall", int'(nvm_pkg::MAP_STALL_CYCLES), st)
		// frozen block ignores a store: no stall, buffer slot kept
		ce <= 1'b0;
		core_u.store({3'h3, m}, ~v, st);
		ce <= 1'b1;
		`CHECK("frozen stall", 0, st)
		wr(nvm_pkg::OFS_ADDR, {3'h3, m});
		run(nvm_pkg::CMD_WRITE_PAGE);
		core_u.fetch(1, {3'h3, m}, d);
		`CHECK("mapped cell", v, d)
		core_u.fetch(1, {3'h3, k}, d);
		`CHECK("mapped reg load", nvm_pkg::ERASED_BYTE, d)
		wr(nvm_pkg::OFS_DATA_BYTE0_REG, 8'hA5);
		ee_rd({3'h3, m}, d);
		`CHECK("mapped reg read", 8'hA5, d)
		wrap_up();
	end
endmodule : test_nvm_cmd_ctrl

// ---- verilog/nvm_byte_mem.sv ----
// byte-wide memory, one write port, one registered read port
// assumes clk, arst_n and ce are shared with the command block
`timescale 1ns/1ps
module nvm_byte_mem #(
	parameter int AW = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// write port
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [7:0] wrData,
	// read port
	input wire logic [AW-1:0] rdAddr,
	output logic [7:0] rdData
);

	logic [7:0] cells [0:(1<<AW)-1];

	// array has no reset, contents survive like the real cells
	always_ff @(posedge clk) begin
		if (ce && wrEn) begin
			cells[wrAddr] <= wrData;
		end
	end

	// read data from a register, one cycle after the address
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData <= 8'h00;
		end else if (ce) begin
			rdData <= cells[rdAddr];
		end
	end

endmodule : nvm_byte_mem

// ---- verilog/nvm_cmd_ctrl.sv ----
// command logic for signature, fuse, lock and eeprom operations
// assumes a Wishbone master on clk, guard window and fuse pins outside
//
// Summary of operation
// - signature read returns byte on load instr
// - action commands start on execute trigger bit
// - read-triggered commands start on program load instr
// - protected triggers need guard window unless external
// - read fuses: address selects, data_byte0_reg gets value
// - write lock from data_byte0_reg, busy and halted
// - lock bits only move toward more secure
// - lock write clears eeprom and flash buffers
// - lock write accepted from any code section
// - eeprom byte or page write, byte read
// - eeprom via registers or mapped data space
// - address splits into byte and page fields
// - mapped stores load buffer by low bits
// - mapped buffer load stalls core two cycles
// - mapping disables register buffer load and read
// - data_byte0_reg write loads buffer slot, no busy
// - buffer erase on trigger, busy, protected
// - page erase, write, erase-write on trigger
// - page write touches only tagged slots
// - eeprom erase clears tagged slots every page
// - eeprom read puts byte into data_byte0_reg
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module nvm_cmd_ctrl (
	// clock, reset, enable
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// wishbone slave
	input wire nvm_pkg::wbReq_type wbReq,
	output logic wbAck,
	output logic [31:0] wbDat,
	// core side
	input wire nvm_pkg::coreReq_type core,
	output logic [7:0] lpmData,
	output logic lpmValid,
	output logic [7:0] mapRdata,
	output logic mapRvalid,
	output logic coreHalt,
	// protection and fuse pins
	input wire logic guardOpen,
	input wire logic extProg,
	input wire logic [nvm_pkg::FUSE_COUNT*8-1:0] fusePins,
	// status toward neighbours
	output logic nvmBusy,
	output logic flashBufClear
);

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} state_type;

	function automatic logic hits(input logic [7:0] adr, input logic [7:0] ofs);
		hits = (adr == ofs);
	endfunction : hits

	// trigger kind of each command
	function automatic nvm_pkg::trig_type trigOf(input logic [6:0] c);
		unique case (c)
			nvm_pkg::CMD_READ_USER_SIG, nvm_pkg::CMD_READ_PROD_SIG:
				trigOf = nvm_pkg::TRIG_LPM;
			nvm_pkg::CMD_LOAD_BUFFER: trigOf = nvm_pkg::TRIG_DATA_BYTE0_REG;
			nvm_pkg::CMD_READ_FUSES, nvm_pkg::CMD_WRITE_LOCK,
			nvm_pkg::CMD_READ_EEPROM, nvm_pkg::CMD_ERASE_EEPROM,
			nvm_pkg::CMD_ERASE_PAGE, nvm_pkg::CMD_WRITE_PAGE,
			nvm_pkg::CMD_ERASE_WRITE_PAGE, nvm_pkg::CMD_ERASE_BUFFER:
				trigOf = nvm_pkg::TRIG_EXEC;
			default: trigOf = nvm_pkg::TRIG_NONE;
		endcase
	endfunction : trigOf

	function automatic logic isGuarded(input logic [6:0] c);
		isGuarded = (trigOf(c) == nvm_pkg::TRIG_EXEC)
			&& (c != nvm_pkg::CMD_READ_FUSES);
	endfunction : isGuarded

	function automatic logic isWalk(input logic [6:0] c);
		isWalk = (c == nvm_pkg::CMD_ERASE_PAGE) || (c == nvm_pkg::CMD_ERASE_EEPROM)
			|| (c == nvm_pkg::CMD_WRITE_PAGE)
			|| (c == nvm_pkg::CMD_ERASE_WRITE_PAGE);
	endfunction : isWalk

	// pin synchroniser for the fuse straps
	logic [nvm_pkg::FUSE_COUNT*8-1:0] fuseMeta_reg, fuseSync_reg;
	// register file
	logic [7:0] addr_reg, data_byte0_reg_reg, lock_reg;
	logic [6:0] cmd_reg, op_reg;
	logic mapEn_reg, ack_reg, busy_reg, halt_reg, lpmValid_reg;
	logic mapRvalid_reg, flashClr_reg;
	logic [31:0] dat_reg;
	logic [7:0] lpmData_reg, opAddr_reg, idx_reg;
	logic [1:0] stall_reg, stall_next;
	logic [nvm_pkg::PAGE_BYTES-1:0] tag_reg;
	state_type state_reg, state_next;
	// walk pipeline: write one cycle after the buffer read
	logic pipeValid_reg, pipeErase_reg;
	logic [nvm_pkg::EE_AW-1:0] pipeAddr_reg;
	logic wbHit, regWr, regRd, execWr, data0Wr, startOp, opLast;
	logic bufWe, eeWe, mapStoreOk, halt_next;
	logic [nvm_pkg::BUF_AW-1:0] bufWrAddr, slot;
	logic [7:0] bufWrData, bufRdata, eeRdata, eeWrData, rdMux;
	logic [nvm_pkg::EE_AW-1:0] eeRdAddr;

	assign wbHit = wbReq.cyc && wbReq.stb && !ack_reg;
	// writes land at the edge where the master samples ack high
	assign regWr = wbReq.cyc && wbReq.stb && ack_reg && wbReq.we
		&& wbReq.sel[0];
	assign regRd = wbHit && !wbReq.we;
	assign execWr = regWr && hits(wbReq.adr, nvm_pkg::OFS_CONTROL_A_REG)
		&& wbReq.dat[nvm_pkg::CONTROL_A_REG_EXEC_BIT];
	assign data0Wr = regWr && hits(wbReq.adr, nvm_pkg::OFS_DATA_BYTE0_REG);
	assign mapStoreOk = core.mapStore && mapEn_reg;

	// exec accepted only when idle, guard open or external for protected codes
	assign startOp = execWr && (state_reg == ST_IDLE)
		&& (trigOf(cmd_reg) == nvm_pkg::TRIG_EXEC)
		&& (!isGuarded(cmd_reg) || guardOpen || extProg)
		&& !(mapEn_reg && cmd_reg == nvm_pkg::CMD_READ_EEPROM);
	assign slot = idx_reg[nvm_pkg::BUF_AW-1:0];
	assign opLast = (op_reg == nvm_pkg::CMD_ERASE_EEPROM) ? (idx_reg == 8'hFF)
		: (slot == nvm_pkg::BUF_AW'(nvm_pkg::PAGE_BYTES - 1));

	// two flops on the fuse pins before anything reads them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fuseMeta_reg <= '0;
			fuseSync_reg <= '0;
		end else if (ce) begin
			fuseMeta_reg <= fusePins;
			fuseSync_reg <= fuseMeta_reg;
		end
	end

	// wishbone answer one cycle after the request, read data with it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else if (ce) begin
			ack_reg <= wbHit;
			if (regRd) begin
				dat_reg <= {24'h00_0000, rdMux};
			end
		end
	end

	// read mux, unmapped offsets answer zero
	always_comb begin
		rdMux = 8'h00;
		if (hits(wbReq.adr, nvm_pkg::OFS_ADDR)) rdMux = addr_reg;
		if (hits(wbReq.adr, nvm_pkg::OFS_DATA_BYTE0_REG)) rdMux = data_byte0_reg_reg;
		if (hits(wbReq.adr, nvm_pkg::OFS_CMD)) rdMux = {1'b0, cmd_reg};
		if (hits(wbReq.adr, nvm_pkg::OFS_STATUS)) begin
			rdMux[nvm_pkg::STATUS_BUSY_BIT] = busy_reg;
		end
		if (hits(wbReq.adr, nvm_pkg::OFS_CTRLB)) begin
			rdMux[nvm_pkg::CTRLB_MAP_BIT] = mapEn_reg;
		end
		if (hits(wbReq.adr, nvm_pkg::OFS_LOCK)) rdMux = lock_reg;
	end

	// software-written control registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_reg <= 8'h00;
			cmd_reg <= nvm_pkg::CMD_NOP;
			mapEn_reg <= 1'b0;
		end else if (ce && regWr) begin
			if (hits(wbReq.adr, nvm_pkg::OFS_ADDR)) addr_reg <= wbReq.dat[7:0];
			if (hits(wbReq.adr, nvm_pkg::OFS_CMD)) cmd_reg <= wbReq.dat[6:0];
			if (hits(wbReq.adr, nvm_pkg::OFS_CTRLB)) begin
				mapEn_reg <= wbReq.dat[nvm_pkg::CTRLB_MAP_BIT];
			end
		end
	end

	// data_byte0_reg: software, fuse result, eeprom read result
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_byte0_reg_reg <= 8'h00;
		end else if (ce) begin
			if (state_reg == ST_RUN && op_reg == nvm_pkg::CMD_READ_FUSES) begin
				data_byte0_reg_reg <= (opAddr_reg < 8'(nvm_pkg::FUSE_COUNT))
					? fuseSync_reg[opAddr_reg[2:0]*8 +: 8] : 8'h00;
			end else if (state_reg == ST_DONE
					&& op_reg == nvm_pkg::CMD_READ_EEPROM) begin
				data_byte0_reg_reg <= eeRdata;
			end else if (data0Wr) begin
				data_byte0_reg_reg <= wbReq.dat[7:0];
			end
		end
	end

	// lock bits: and-in only, zero means programmed (more secure)
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_reg <= nvm_pkg::LOCK_RESET;
		end else if (ce && state_reg == ST_RUN
				&& op_reg == nvm_pkg::CMD_WRITE_LOCK) begin
			lock_reg <= lock_reg & data_byte0_reg_reg;
		end
	end

	// command sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: if (startOp) state_next = ST_RUN;
			ST_RUN: if (!isWalk(op_reg) || opLast) state_next = ST_DONE;
			ST_DONE: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			op_reg <= nvm_pkg::CMD_NOP;
			opAddr_reg <= 8'h00;
			idx_reg <= 8'h00;
		end else if (ce) begin
			state_reg <= state_next;
			if (startOp) begin
				op_reg <= cmd_reg;
				opAddr_reg <= addr_reg;
				idx_reg <= 8'h00;
			end else if (state_reg == ST_RUN) begin
				idx_reg <= idx_reg + 8'h01;
			end
		end
	end

	// busy for every exec command except eeprom read; cleared after done
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_reg <= 1'b0;
		end else if (ce) begin
			if (startOp) begin
				busy_reg <= (cmd_reg != nvm_pkg::CMD_READ_EEPROM);
			end else if (state_reg == ST_DONE) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// halt: fuse/lock commands, plus two-cycle mapped store stall
	always_comb begin
		stall_next = (stall_reg != 2'h0) ? stall_reg - 2'h1 : 2'h0;
		if (mapStoreOk) stall_next = nvm_pkg::MAP_STALL_CYCLES;
		halt_next = (stall_next != 2'h0);
		if (startOp && (cmd_reg == nvm_pkg::CMD_READ_FUSES
				|| cmd_reg == nvm_pkg::CMD_WRITE_LOCK)) begin
			halt_next = 1'b1;
		end
		// held through done so halt and busy drop on the same edge
		if (state_reg == ST_RUN && (op_reg == nvm_pkg::CMD_READ_FUSES
				|| op_reg == nvm_pkg::CMD_WRITE_LOCK)) begin
			halt_next = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stall_reg <= 2'h0;
			halt_reg <= 1'b0;
		end else if (ce) begin
			stall_reg <= stall_next;
			halt_reg <= halt_next;
		end
	end

	// page buffer write port: mapped store wins over data_byte0_reg load
	always_comb begin
		bufWe = 1'b0;
		bufWrAddr = addr_reg[nvm_pkg::BYTE_TOP:0];
		bufWrData = data_byte0_reg_reg;
		if (mapStoreOk) begin
			bufWe = 1'b1;
			bufWrAddr = core.addr[nvm_pkg::BYTE_TOP:0];
			bufWrData = core.data;
		end else if (data0Wr && !mapEn_reg
				&& cmd_reg == nvm_pkg::CMD_LOAD_BUFFER) begin
			bufWe = 1'b1;
			bufWrData = wbReq.dat[7:0];
		end
	end

	// tags: a load sets a slot, buffer erase and lock write clear all
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tag_reg <= '0;
			flashClr_reg <= 1'b0;
		end else if (ce) begin
			flashClr_reg <= 1'b0;
			if (state_reg == ST_RUN && (op_reg == nvm_pkg::CMD_ERASE_BUFFER
					|| op_reg == nvm_pkg::CMD_WRITE_LOCK)) begin
				tag_reg <= '0;
				flashClr_reg <= (op_reg == nvm_pkg::CMD_WRITE_LOCK);
			end
			if (bufWe) begin // a load in the clearing cycle wins
				tag_reg[bufWrAddr] <= 1'b1;
			end
		end
	end

	// walk stage: a tagged slot issues a cell write next cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pipeValid_reg <= 1'b0;
			pipeErase_reg <= 1'b0;
			pipeAddr_reg <= '0;
		end else if (ce) begin
			pipeValid_reg <= (state_reg == ST_RUN) && isWalk(op_reg)
				&& tag_reg[slot];
			pipeErase_reg <= (op_reg == nvm_pkg::CMD_ERASE_PAGE)
				|| (op_reg == nvm_pkg::CMD_ERASE_EEPROM);
			pipeAddr_reg <= (op_reg == nvm_pkg::CMD_ERASE_EEPROM) ? idx_reg
				: {opAddr_reg[nvm_pkg::PAGE_TOP:nvm_pkg::BYTE_TOP+1], slot};
		end
	end

	// erase-write lands the buffer byte, so one write covers both
	assign eeWe = pipeValid_reg;
	assign eeWrData = pipeErase_reg ? nvm_pkg::ERASED_BYTE : bufRdata;
	assign eeRdAddr = mapEn_reg ? core.addr : opAddr_reg;

	nvm_byte_mem #(.AW(nvm_pkg::BUF_AW)) pageBuf (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.wrEn(bufWe),
		.wrAddr(bufWrAddr),
		.wrData(bufWrData),
		.rdAddr(slot),
		.rdData(bufRdata)
	);

	nvm_byte_mem #(.AW(nvm_pkg::EE_AW)) eeCells (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.wrEn(eeWe),
		.wrAddr(pipeAddr_reg),
		.wrData(eeWrData),
		.rdAddr(eeRdAddr),
		.rdData(eeRdata)
	);

	// signature row and mapped read answers, one cycle after request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lpmValid_reg <= 1'b0;
			lpmData_reg <= 8'h00;
			mapRvalid_reg <= 1'b0;
		end else if (ce) begin
			lpmValid_reg <= core.lpmReq
				&& (trigOf(cmd_reg) == nvm_pkg::TRIG_LPM);
			if (core.lpmReq) begin
				lpmData_reg <= core.addr ^ ((cmd_reg == nvm_pkg::CMD_READ_PROD_SIG)
					? nvm_pkg::SIG_SEED_PROD : nvm_pkg::SIG_SEED_USER);
			end
			mapRvalid_reg <= core.mapLoad && mapEn_reg;
		end
	end

	assign wbAck = ack_reg;
	assign wbDat = dat_reg;
	assign lpmData = lpmData_reg;
	assign lpmValid = lpmValid_reg;
	assign mapRdata = eeRdata;
	assign mapRvalid = mapRvalid_reg;
	assign coreHalt = halt_reg;
	assign nvmBusy = busy_reg;
	assign flashBufClear = flashClr_reg;

	chk_busy_drop: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && state_reg == ST_DONE) |=> !busy_reg && !halt_reg)
		else $error("busy or halt stayed after completion");

	chk_guard_block: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && execWr && isGuarded(cmd_reg) && !guardOpen && !extProg)
		|=> !$rose(busy_reg) && state_reg != ST_RUN || $past(state_reg) != ST_IDLE)
		else $error("protected command started without guard");

	chk_nop_idle: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && execWr && state_reg == ST_IDLE && cmd_reg == nvm_pkg::CMD_NOP)
		|=> state_reg == ST_IDLE)
		else $error("no-op command left idle");

	chk_map_stall: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && mapStoreOk) |=> halt_reg [*2])
		else $error("mapped store did not stall two cycles");

	chk_lock_secure: assert property (@(posedge clk) disable iff (!arst_n)
		(lock_reg & ~$past(lock_reg)) == 8'h00)
		else $error("lock bit went back to unprogrammed");

	chk_lock_clears: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && state_reg == ST_RUN && op_reg == nvm_pkg::CMD_WRITE_LOCK
		&& !bufWe) |=> tag_reg == '0 && flashBufClear)
		else $error("lock write left buffers loaded");

	chk_map_blocks: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && data0Wr && mapEn_reg && !core.mapStore && state_reg == ST_IDLE
		&& cmd_reg == nvm_pkg::CMD_LOAD_BUFFER) |=> $stable(tag_reg))
		else $error("register load worked while mapped");

	chk_fuse_halt: assert property (@(posedge clk) disable iff (!arst_n)
		(state_reg == ST_RUN && op_reg == nvm_pkg::CMD_READ_FUSES)
		|-> halt_reg && busy_reg)
		else $error("fuse read not busy and halted");

	chk_sig_read: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && core.lpmReq && cmd_reg == nvm_pkg::CMD_READ_USER_SIG)
		|=> lpmValid && lpmData == ($past(core.addr) ^ nvm_pkg::SIG_SEED_USER))
		else $error("signature byte not returned");

	chk_buf_load: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && data0Wr && !mapEn_reg && !core.mapStore && state_reg == ST_IDLE
		&& cmd_reg == nvm_pkg::CMD_LOAD_BUFFER)
		|=> tag_reg[$past(addr_reg[nvm_pkg::BYTE_TOP:0])] && !busy_reg)
		else $error("data_byte0_reg write did not load buffer slot");

endmodule : nvm_cmd_ctrl
